// ===== hw/dbsp_port.sv
// Device side of a DDR burst-of-two SRAM: link pins in, array, echo clocks out
// Assumes both link clocks and all pins are asynchronous to core_clk and much slower
`timescale 1ns/1ps
`include "dbsp_map.svh"

module dbsp_port
    import dbsp_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic k_clk,
    input wire logic k_clk_n,
    input wire logic pll_disable_n,
    input wire logic load_strobe_n,
    input wire logic read_write_sel,
    input wire logic [`DBSP_ADDR_W-1:0] address,
    input wire logic [`DBSP_WORD_W-1:0] dq_in,
    input wire logic [`DBSP_BYTES-1:0] byte_write_select_n,
    output logic [`DBSP_WORD_W-1:0] dq_out,
    output logic dq_oe,
    output logic read_data_valid,
    output logic echo_clock,
    output logic echo_clock_n,
    output logic pll_locked,
    output logic impedance_update
);

    localparam int SYNC_W = 5 + `DBSP_ADDR_W + `DBSP_WORD_W + `DBSP_BYTES;

    ////////////////////////////////////////////////////////////////////////////////
    // Two-flop synchronisers for every pin, then edge detect on the second stage
    logic [SYNC_W-1:0] sync1;
    logic [SYNC_W-1:0] sync2;
    logic k_prev;
    logic kn_prev;

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            sync1 <= '0;
            sync2 <= '0;
        end else begin
            sync1 <= {k_clk, k_clk_n, pll_disable_n, load_strobe_n, read_write_sel,
                      address, dq_in, byte_write_select_n};
            sync2 <= sync1;
        end
    end

    logic k_s;
    logic kn_s;
    logic pll_on;
    logic ld_n_s;
    logic rw_s;
    logic [`DBSP_ADDR_W-1:0] addr_s;
    logic [`DBSP_WORD_W-1:0] dq_s;
    logic [`DBSP_BYTES-1:0] bws_n_s;

    assign {k_s, kn_s, pll_on, ld_n_s, rw_s, addr_s, dq_s, bws_n_s} = sync2;

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            k_prev <= 1'b0;
            kn_prev <= 1'b0;
        end else begin
            k_prev <= k_s;
            kn_prev <= kn_s;
        end
    end

    logic k_rise;
    logic kn_rise;
    logic half_edge;

    assign k_rise = k_s & ~k_prev;
    assign kn_rise = kn_s & ~kn_prev;
    assign half_edge = k_rise | kn_rise;

    // Commands only on positive rises; load strobe high is a NOP
    logic rd_cmd;
    logic wr_cmd;

    assign rd_cmd = k_rise & ~ld_n_s & rw_s;
    assign wr_cmd = k_rise & ~ld_n_s & ~rw_s;

    ////////////////////////////////////////////////////////////////////////////////
    // Two arrays, one per burst word, and the posted write register
    logic [`DBSP_WORD_W-1:0] array0 [`DBSP_DEPTH];
    logic [`DBSP_WORD_W-1:0] array1 [`DBSP_DEPTH];

    function automatic logic [`DBSP_WORD_W-1:0] merge(
        input logic [`DBSP_WORD_W-1:0] old_w,
        input logic [`DBSP_WORD_W-1:0] new_w,
        input logic [`DBSP_BYTES-1:0] sel_n
    );
        logic [`DBSP_WORD_W-1:0] res;
        res = old_w;
        for (int b = 0; b < `DBSP_BYTES; b++) begin
            if (!sel_n[b]) begin
                res[b*`DBSP_BYTE_W +: `DBSP_BYTE_W] = new_w[b*`DBSP_BYTE_W +: `DBSP_BYTE_W];
            end
        end
        return res;
    endfunction : merge

    dbsp_wr_state_t wr_state;
    dbsp_wr_t wr_fill;
    dbsp_wr_t wr_post;
    logic post_valid;
    logic wr_cmd_pending;
    logic [`DBSP_ADDR_W-1:0] wr_next_addr;

    // Write capture: address at command, word one at next K rise, word two at K# rise
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            wr_state <= DBSP_WR_IDLE;
            wr_fill <= '0;
        end else begin
            case (wr_state)
                DBSP_WR_IDLE: begin
                    if (wr_cmd) begin
                        wr_fill.addr <= addr_s;
                        wr_state <= DBSP_WR_WORD0;
                    end
                end
                DBSP_WR_WORD0: begin
                    if (k_rise) begin
                        wr_fill.data0 <= dq_s;
                        wr_fill.mask0_n <= bws_n_s;
                        wr_state <= DBSP_WR_WORD1;
                    end
                end
                DBSP_WR_WORD1: begin
                    if (kn_rise) begin
                        wr_fill.data1 <= dq_s;
                        wr_fill.mask1_n <= bws_n_s;
                        if (wr_cmd_pending) begin
                            wr_fill.addr <= wr_next_addr;
                            wr_state <= DBSP_WR_WORD0;
                        end else begin
                            wr_state <= DBSP_WR_IDLE;
                        end
                    end else if (wr_cmd) begin
                        // Cannot occur with a legal K/K# order; keep the newest address
                        wr_fill.addr <= addr_s;
                    end
                end
                default: begin
                    wr_state <= DBSP_WR_IDLE;
                end
            endcase
        end
    end

    // A back-to-back write arrives on the same K rise that takes word one

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            wr_cmd_pending <= 1'b0;
            wr_next_addr <= '0;
        end else if (wr_state == DBSP_WR_WORD0 && wr_cmd) begin
            wr_cmd_pending <= 1'b1;
            wr_next_addr <= addr_s;
        end else if (wr_state == DBSP_WR_WORD1 && kn_rise) begin
            wr_cmd_pending <= 1'b0;
        end
    end

    // Completed bursts wait in the posted register until the next write command or the next burst completes
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            wr_post <= '0;
            post_valid <= 1'b0;
        end else if (wr_state == DBSP_WR_WORD1 && kn_rise) begin
            wr_post <= '{addr: wr_fill.addr, data0: wr_fill.data0, data1: dq_s,
                         mask0_n: wr_fill.mask0_n, mask1_n: bws_n_s};
            post_valid <= 1'b1;
        end else if (wr_cmd && post_valid) begin
            post_valid <= 1'b0;
        end
    end

    // Both words committed together, 36 bits, on the next write command or just before
    // a newer burst takes the posted register, so back-to-back writes are not lost
    always_ff @(posedge core_clk) begin
        if (post_valid && (wr_cmd || (wr_state == DBSP_WR_WORD1 && kn_rise))) begin
            array0[wr_post.addr] <= merge(array0[wr_post.addr], wr_post.data0,
                                          wr_post.mask0_n);
            array1[wr_post.addr] <= merge(array1[wr_post.addr], wr_post.data1,
                                          wr_post.mask1_n);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read pipeline: one slot per link half-edge, command enters at its K rise
    dbsp_cmd_t rd_pipe [`DBSP_PIPE_LEN];

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < `DBSP_PIPE_LEN; i++) begin
                rd_pipe[i] <= '0;
            end
        end else if (half_edge) begin
            rd_pipe[0] <= '{valid: rd_cmd, addr: addr_s};
            for (int i = 1; i < `DBSP_PIPE_LEN; i++) begin
                rd_pipe[i] <= rd_pipe[i-1];
            end
        end
    end

    // Word positions in the pipe depend on the latency mode
    logic [2:0] w0_slot;
    logic [2:0] w1_slot;
    dbsp_cmd_t w0_cmd;
    dbsp_cmd_t w1_cmd;
    logic vld_next;

    always_comb begin
        if (pll_on) begin
            w0_slot = 3'(`DBSP_PLL_WORD0 - 1);
        end else begin
            w0_slot = 3'(`DBSP_LEG_WORD0 - 1);
        end
        w1_slot = w0_slot + 3'h1;
        w0_cmd = rd_pipe[w0_slot];
        w1_cmd = rd_pipe[w1_slot];
        // Valid leads the data by one half-edge and drops a half-edge before it ends
        vld_next = rd_pipe[w0_slot - 3'h1].valid | w0_cmd.valid;
    end

    // Read word with bypass from the posted register on an address match
    logic [`DBSP_WORD_W-1:0] rd_word0;
    logic [`DBSP_WORD_W-1:0] rd_word1;
    logic hit0;
    logic hit1;

    assign hit0 = post_valid && wr_post.addr == w0_cmd.addr;
    assign hit1 = post_valid && wr_post.addr == w1_cmd.addr;
    assign rd_word0 = hit0 ? merge(array0[w0_cmd.addr], wr_post.data0, wr_post.mask0_n)
                           : array0[w0_cmd.addr];
    assign rd_word1 = hit1 ? merge(array1[w1_cmd.addr], wr_post.data1, wr_post.mask1_n)
                           : array1[w1_cmd.addr];

    // Output registers launched on either half-edge; float one edge after last word
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            dq_out <= '0;
            dq_oe <= 1'b0;
            read_data_valid <= 1'b0;
        end else if (half_edge) begin
            read_data_valid <= vld_next;
            if (w0_cmd.valid) begin
                dq_out <= rd_word0;
                dq_oe <= 1'b1;
            end else if (w1_cmd.valid) begin
                dq_out <= rd_word1;
                dq_oe <= 1'b1;
            end else begin
                dq_oe <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Echo clocks follow the sampled link clocks, one per phase
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            echo_clock <= 1'b0;
            echo_clock_n <= 1'b0;
        end else begin
            echo_clock <= k_s;
            echo_clock_n <= kn_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Impedance update pulse every 1024 positive link rises
    logic [`DBSP_CAL_CNT_W-1:0] cal_cnt;

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            cal_cnt <= '0;
            impedance_update <= 1'b0;
        end else begin
            impedance_update <= 1'b0;
            if (k_rise) begin
                cal_cnt <= cal_cnt + `DBSP_CAL_CNT_W'(1);
                if (cal_cnt == `DBSP_CAL_CNT_W'(`DBSP_CAL_CYCLES - 1)) begin
                    impedance_update <= 1'b1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // PLL lock: count stable clock time, restart when the link clock stalls
    logic [`DBSP_LOCK_CNT_W-1:0] lock_cnt;
    logic [`DBSP_STOP_CNT_W-1:0] gap_cnt;
    logic stalled;

    assign stalled = gap_cnt >= `DBSP_STOP_CNT_W'(`DBSP_STOP_CYCLES);

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            gap_cnt <= '0;
        end else if (half_edge) begin
            gap_cnt <= '0;
        end else if (!stalled) begin
            gap_cnt <= gap_cnt + `DBSP_STOP_CNT_W'(1);
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            lock_cnt <= '0;
            pll_locked <= 1'b0;
        end else if (!pll_on || stalled) begin
            lock_cnt <= '0;
            pll_locked <= 1'b0;
        end else if (lock_cnt == `DBSP_LOCK_CNT_W'(`DBSP_LOCK_CYCLES - 1)) begin
            pll_locked <= 1'b1;
        end else begin
            lock_cnt <= lock_cnt + `DBSP_LOCK_CNT_W'(1);
        end
    end

endmodule : dbsp_port

// ===== hw/dbsp_map.svh
// Constants of the DDR burst-of-two SRAM port: widths, latencies and timing counts
// Assumes a 100 MHz core clock that oversamples the slower link clocks
//
// What this block does
// - PLL-disable input high: read data comes 2.5 link cycles after the command
// - PLL-disable input low: legacy mode, read latency of one link cycle
// - Accesses begin only on positive link clock rises, never the negative clock
// - Write data taken, read data launched, on rises of both link clocks
// - Read/write select, load strobe sampled only on positive rise; byte selects on both rises
// - Each access moves two sequential 18-bit words from two internal arrays
// - Read/write select high with load strobe low starts a read; address stored
// - PLL on: first read word after two positive rises, second on opposite clock edge
// - A new read may be accepted on every positive rise
// - After deselect, pending reads finish, then outputs float one half-edge after the last word
// - Read/write select low with load strobe low starts a write; address stored
// - Word one on next positive rise, word two on negative rise, commit 36 bits
// - A new write may be accepted on every positive rise
// - After write deselect, pending write completes, then inputs ignored
// - Active-low byte selects sampled per word; deasserted byte stays unchanged
// - Write followed by read is held in registers and committed on next write
// - Read of the just-written address returns the selected bytes from the register, the rest from the array
// - Output impedance recalibrated every 1024 link clock cycles
// - Two free-running echo clocks follow the two link clock phases
// - Read-data-valid aligned with echo clocks, rises half a cycle before data
// - PLL locks 20 us after stable clock; a 30 ns stop resets it
// - PLL on: first word on negative rise two cycles later, second on next rise
// - Second burst word lives in the second array at the burst's own address
// - Powers up deselected, outputs floating; load strobe high is a NOP
`ifndef DBSP_MAP_SVH
`define DBSP_MAP_SVH

`define DBSP_ADDR_W 20
`define DBSP_WORD_W 18
`define DBSP_BYTE_W 9
`define DBSP_BYTES 2
`define DBSP_DEPTH 1048576
`define DBSP_PIPE_LEN 6
// Half-edge offsets from the command edge to the data words
`define DBSP_PLL_WORD0 5
`define DBSP_LEG_WORD0 2
`define DBSP_CAL_CYCLES 1024
`define DBSP_CAL_CNT_W 10
`define DBSP_CORE_MHZ 100
`define DBSP_LOCK_US 20
`define DBSP_LOCK_CYCLES (`DBSP_LOCK_US * `DBSP_CORE_MHZ)
`define DBSP_LOCK_CNT_W 12
`define DBSP_STOP_NS 30
`define DBSP_K_HALF_NS 40
`define DBSP_CORE_NS 10
`define DBSP_STOP_CYCLES ((`DBSP_K_HALF_NS + `DBSP_STOP_NS) / `DBSP_CORE_NS)
`define DBSP_STOP_CNT_W 4

`endif

// ===== hw/dbsp_pkg.sv
// Types shared by the DDR burst-of-two SRAM port
// Assumes dbsp_map.svh is on the include path
`include "dbsp_map.svh"

package dbsp_pkg;

    typedef struct packed {
        logic valid;
        logic [`DBSP_ADDR_W-1:0] addr;
    } dbsp_cmd_t;

    typedef struct packed {
        logic [`DBSP_ADDR_W-1:0] addr;
        logic [`DBSP_WORD_W-1:0] data0;
        logic [`DBSP_WORD_W-1:0] data1;
        logic [`DBSP_BYTES-1:0] mask0_n;
        logic [`DBSP_BYTES-1:0] mask1_n;
    } dbsp_wr_t;

    typedef enum logic [1:0] {
        DBSP_WR_IDLE,
        DBSP_WR_WORD0,
        DBSP_WR_WORD1
    } dbsp_wr_state_t;

endpackage : dbsp_pkg

// ===== tb/dbsp_port_props.sv
// Pin-level assertions for the burst SRAM port
// Assumes one core clock domain; link pins are oversampled raw
`timescale 1ns/1ps
`include "dbsp_map.svh"
module dbsp_port_props (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic k_clk,
    input wire logic k_clk_n,
    input wire logic pll_disable_n,
    input wire logic load_strobe_n,
    input wire logic read_write_sel,
    input wire logic [`DBSP_WORD_W-1:0] dq_out,
    input wire logic dq_oe,
    input wire logic read_data_valid,
    input wire logic echo_clock,
    input wire logic echo_clock_n,
    input wire logic pll_locked,
    input wire logic impedance_update
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);
    logic k_q;
    logic [2:0] quiet;
    logic [10:0] kcnt;
    logic [11:0] ccnt;
    // K rises since the last read command, link rises between pulses, lock time
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            k_q <= 1'b0;
            quiet <= 3'h7;
            kcnt <= 11'h0;
            ccnt <= 12'h0;
        end else begin
            k_q <= k_clk;
            if (k_clk && !k_q && !load_strobe_n && read_write_sel) begin
                quiet <= 3'h0;
            end else if (k_clk && !k_q && quiet != 3'h7) begin
                quiet <= quiet + 3'h1;
            end
            if (impedance_update) begin
                kcnt <= 11'h0;
            end else if (k_clk && !k_q) begin
                kcnt <= kcnt + 11'h1;
            end
            if (!pll_disable_n) begin
                ccnt <= 12'h0;
            end else if (ccnt != 12'hFFF) begin
                ccnt <= ccnt + 12'h1;
            end
        end
    end
    ////////////////////////////////////////
    AST_RESET_IDLE: assert property (
        $fell(reset) |-> !dq_oe && !read_data_valid) else $error("outputs live after reset");
    AST_ECHO_K: assert property (
        $rose(k_clk) |-> ##[2:6] $rose(echo_clock)) else $error("echo clock lost K");
    AST_ECHO_KN: assert property (
        $rose(k_clk_n) |-> ##[2:6] $rose(echo_clock_n)) else $error("echo clock lost K#");
    AST_DV_LEAD: assert property (
        $rose(dq_oe) |-> read_data_valid && $past(read_data_valid, 2))
        else $error("data valid did not lead data");
    AST_DV_THEN_DATA: assert property (
        $rose(read_data_valid) |-> ##[2:6] dq_oe) else $error("no data after data valid");
    AST_DV_HALF: assert property (
        $rose(read_data_valid) |-> ##[3:5] $rose(dq_oe))
        else $error("data valid not half a cycle ahead of data");
    AST_OE_RELEASE: assert property (
        $fell(read_data_valid) |-> ##[2:6] !dq_oe) else $error("outputs not released");
    AST_WORD_HOLD: assert property (
        $rose(dq_oe) |=> $stable(dq_out) [*2]) else $error("first word not held");
    AST_OE_QUIET: assert property (
        quiet >= 3'h5 |-> !dq_oe && !read_data_valid) else $error("output without read");
    AST_IMP_PERIOD: assert property (
        impedance_update |-> kcnt inside {[11'h3FF:11'h401]}) else $error("bad recal period");
    AST_LOCK_TIME: assert property (
        $rose(pll_locked) |-> ccnt inside {[12'h7C6:12'h7E4]}) else $error("bad lock time");
    cover property ($rose(dq_oe));
    cover property ($rose(pll_locked));
    cover property (impedance_update);
endmodule : dbsp_port_props

bind dbsp_port dbsp_port_props props (.core_clk, .reset, .k_clk, .k_clk_n, .pll_disable_n,
    .load_strobe_n, .read_write_sel, .dq_out, .dq_oe, .read_data_valid, .echo_clock,
    .echo_clock_n, .pll_locked, .impedance_update);

// ===== tb/dbsp_ctl_model.sv
// Memory controller model: free link clocks, commands, posted write words
// Assumes the bench calls beat once per link cycle
`timescale 1ns/1ps
`include "dbsp_map.svh"
module dbsp_ctl_model (
    output logic k_clk,
    output logic k_clk_n,
    output logic load_strobe_n,
    output logic read_write_sel,
    output logic [`DBSP_ADDR_W-1:0] address,
    output logic [`DBSP_WORD_W-1:0] ctl_dq,
    output logic [`DBSP_BYTES-1:0] byte_write_select_n
);
    logic wp;
    logic [17:0] pd0;
    logic [17:0] pd1;
    logic [1:0] pm0;
    logic [1:0] pm1;
    initial begin
        k_clk = 1'b0;
        k_clk_n = 1'b1;
        load_strobe_n = 1'b1;
        read_write_sel = 1'b0;
        address = 20'h0;
        ctl_dq = 18'h0;
        byte_write_select_n = 2'h3;
        wp = 1'b0;
        #3.3;
        forever begin
            #40;
            k_clk = ~k_clk;
            k_clk_n = ~k_clk_n;
        end
    end
    // One link cycle; pins change midway between edges, released dq toggles
    task automatic beat(input logic go, input logic rd, input logic [19:0] a,
        input logic [17:0] d0, input logic [17:0] d1, input logic [1:0] m0, input logic [1:0] m1);
        @(posedge k_clk_n);
        #20;
        load_strobe_n = !go;
        read_write_sel = rd;
        address = go ? a : ~address;
        ctl_dq = wp ? pd0 : ~ctl_dq;
        byte_write_select_n = wp ? pm0 : 2'h3;
        @(posedge k_clk);
        #20;
        ctl_dq = wp ? pd1 : ~ctl_dq;
        byte_write_select_n = wp ? pm1 : 2'h3;
        wp = go && !rd;
        {pd0, pd1, pm0, pm1} = {d0, d1, m0, m1};
    endtask : beat
endmodule : dbsp_ctl_model

// ===== tb/dbsp_port_tb.sv
// Self-checking bench for the burst SRAM port
// Assumes the controller model and the bound checker
`timescale 1ns/1ps
`include "dbsp_map.svh"
module dbsp_port_tb;
    logic core_clk;
    logic reset;
    logic pll_disable_n;
    logic k_clk;
    logic k_clk_n;
    logic load_strobe_n;
    logic read_write_sel;
    logic [`DBSP_ADDR_W-1:0] address;
    logic [`DBSP_WORD_W-1:0] ctl_dq;
    logic [`DBSP_WORD_W-1:0] dq_in;
    logic [`DBSP_BYTES-1:0] byte_write_select_n;
    logic [`DBSP_WORD_W-1:0] dq_out;
    logic dq_oe;
    logic read_data_valid;
    logic pll_locked;
    logic impedance_update;
    int fails;
    int samples_checked;
    logic [17:0] mem0 [8];
    logic [17:0] mem1 [8];
    // Shared dq wire
    assign dq_in = dq_oe ? dq_out : ctl_dq;
    dbsp_ctl_model ctl (.k_clk, .k_clk_n, .load_strobe_n, .read_write_sel, .address, .ctl_dq,
        .byte_write_select_n);
    dbsp_port dut (.core_clk, .reset, .k_clk, .k_clk_n, .pll_disable_n, .load_strobe_n,
        .read_write_sel, .address, .dq_in, .byte_write_select_n, .dq_out, .dq_oe,
        .read_data_valid, .echo_clock(), .echo_clock_n(), .pll_locked, .impedance_update);
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    ////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk
    task automatic results();
        $display("Comparisons %0d, mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : results
    function automatic logic [17:0] mg(input logic [17:0] o, input logic [17:0] n,
        input logic [1:0] m);
        mg = {m[1] ? o[17:9] : n[17:9], m[0] ? o[8:0] : n[8:0]};
    endfunction : mg
    task automatic nop(input int n);
        repeat (n) ctl.beat(1'b0, 1'b0, 20'h0, 18'h0, 18'h0, 2'h0, 2'h0);
    endtask : nop
    task automatic wr(input logic [19:0] a, input logic [17:0] d0, input logic [17:0] d1,
        input logic [1:0] m0, input logic [1:0] m1);
        ctl.beat(1'b1, 1'b0, a, d0, d1, m0, m1);
        mem0[a[2:0]] = mg(mem0[a[2:0]], d0, m0);
        mem1[a[2:0]] = mg(mem1[a[2:0]], d1, m1);
    endtask : wr
    // Samples each word mid-way through its half cycle
    task automatic rd(input logic [19:0] a);
        logic [17:0] e0;
        logic [17:0] e1;
        int w;
        e0 = mem0[a[2:0]];
        e1 = mem1[a[2:0]];
        w = pll_disable_n ? 230 : 110;
        ctl.beat(1'b1, 1'b1, a, 18'h0, 18'h0, 2'h3, 2'h3);
        fork
            begin
                #(w);
                chk(32'(dq_oe), 32'h1);
                chk(32'(dq_out), 32'(e0));
                #40;
                chk(32'(dq_out), 32'(e1));
            end
        join_none
    endtask : rd
    ////////////////////////////////////////
    task automatic t_idle();
        chk(32'({dq_oe, read_data_valid}), 32'h0);
        nop(3);
        chk(32'({dq_oe, read_data_valid}), 32'h0);
    endtask : t_idle
    task automatic t_lock();
        repeat (1850) @(posedge core_clk);
        #1;
        chk(32'(pll_locked), 32'h0);
        repeat (300) @(posedge core_clk);
        #1;
        chk(32'(pll_locked), 32'h1);
    endtask : t_lock
    task automatic t_burst();
        wr(20'h00001, 18'h2AAAA, 18'h15555, 2'h0, 2'h0);
        wr(20'hFFFFF, 18'h3FFFF, 18'h00000, 2'h0, 2'h0);
        rd(20'hFFFFF);
        rd(20'h00001);
        nop(6);
        chk(32'(dq_oe), 32'h0);
    endtask : t_burst
    task automatic t_mask();
        wr(20'h00003, 18'h12345, 18'h0ABCD, 2'h0, 2'h0);
        wr(20'h00003, 18'h3FFFF, 18'h3FFFF, 2'h1, 2'h2);
        wr(20'h00003, 18'h00000, 18'h00000, 2'h3, 2'h3);
        nop(1);
        rd(20'h00003);
        nop(6);
    endtask : t_mask
    task automatic t_legacy();
        @(posedge core_clk);
        pll_disable_n <= 1'b0;
        nop(2);
        rd(20'h00001);
        nop(4);
        @(posedge core_clk);
        pll_disable_n <= 1'b1;
    endtask : t_legacy
    task automatic t_imp();
        int n;
        int c;
        logic kp;
        c = 0;
        for (n = 0; n < 20000 && impedance_update !== 1'b1; n++) begin
            @(posedge core_clk);
            #1;
        end
        kp = k_clk;
        for (n = 0; n < 20000; n++) begin
            @(posedge core_clk);
            #1;
            if (impedance_update === 1'b1) break;
            if (k_clk && !kp) c++;
            kp = k_clk;
        end
        chk(c, 1024);
    endtask : t_imp
    ////////////////////////////////////////
    initial begin
        fails = 0;
        samples_checked = 0;
        reset = 1'b1;
        pll_disable_n = 1'b1;
        repeat (5) @(posedge core_clk);
        reset <= 1'b0;
        t_idle();
        t_lock();
        t_burst();
        t_mask();
        t_legacy();
        t_imp();
        results();
    end
    initial begin
        repeat (40000) @(posedge core_clk);
        fails++;
        results();
    end
endmodule : dbsp_port_tb
